// ### gpio_edge_detect_wakeup.sv
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - Rising edge sets enabled pin rise flag
// - Rise flag cleared by writing enable zero
// - Rise flags raise pin interrupt when enabled
// - Rise register reads flags, writes enables
// - Falling edge sets enabled pin fall flag
// - Fall flag cleared by writing fall enable zero
// - Fall flags raise pin interrupt when enabled
// - Fall register reads flags, writes enables
// - Any enabled edge event wakes CPU; irq_o only when its irq_mask bit is set
// - Wake path edges chosen, filter after detect
// - Pulses shorter than filter time ignored
// - Select field picks one port0/port1 pin
// - Bit 7 enables rising wake-up
// - Rising wake flag set, cleared by enable
// - Bit 6 enables falling wake-up
// - Falling wake flag set, cleared by enable
// - Filter codes 00/10/11 give 1/4/8 ms
module gpio_edge_detect_wakeup
   import gpio_wake_pkg::*;
#(
   parameter int BASE_CYC = GLITCH_BASE_CYC
) (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Synchronous reset
   input wire logic [7:0] port_d_pin_i, // Port 4 pins
   input wire logic [7:0] port_a_pin_i, // Port 0 pins
   input wire logic [7:0] port_b_pin_i, // Port 1 pins
   input wire logic cyc_i, // Wishbone cycle
   input wire logic stb_i, // Wishbone strobe
   input wire logic we_i, // Wishbone write
   input wire logic [15:0] adr_i, // Wishbone byte address
   input wire logic [3:0] sel_i, // Wishbone byte select
   input wire logic [31:0] dat_i, // Wishbone write data
   output logic [31:0] dat_o, // Wishbone read data
   output logic ack_o, // Wishbone acknowledge
   output logic gpio_edge_irq_line_o, // Shared edge interrupt
   output logic wake_o, // CPU wake request pulse
   output logic irq_o // Masked status interrupt
);

   // Elaboration refuses a base that would give a zero-length filter
   if (BASE_CYC < 1) begin : g_bad_base
      $error("BASE_CYC must be at least 1");
   end

   localparam int CW = $clog2(8 * BASE_CYC + 1) + 1;

   typedef struct packed {
      regs_s r;
      logic [7:0] d_s1, d_s2, d_s3;
      logic [15:0] w_s1, w_s2;
      logic w_s3;
      flt_state_e st;
      logic st_rise;
      logic [CW-1:0] cnt;
      logic [31:0] dat;
      logic ack;
      logic edge_irq;
      logic wake;
      logic irq;
   } state_s;

   state_s q, next_q;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [CW-1:0] glitch_cycles(input logic [1:0] code);
      logic [CW-1:0] mult;
      mult = CW'(1) << code;
      return CW'(BASE_CYC) * mult;
   endfunction : glitch_cycles

   function automatic logic hit(input logic [15:0] a, input logic [15:0] want);
      return a[15:2] == want[15:2];
   endfunction : hit

   logic wr, rd_sel, pin_rise, pin_fall, sel_level;
   logic [7:0] d_rise, d_fall;
   logic [2:0] stat_set;

   always_comb begin
      next_q = q;
      wr = cyc_i && stb_i && we_i && !q.ack && sel_i[0];
      rd_sel = 1'b0;
      next_q.d_s1 = port_d_pin_i;
      next_q.d_s2 = q.d_s1;
      next_q.d_s3 = q.d_s2;
      next_q.w_s1 = {port_b_pin_i, port_a_pin_i};
      next_q.w_s2 = q.w_s1;
      d_rise = q.d_s2 & ~q.d_s3;
      d_fall = ~q.d_s2 & q.d_s3;
      sel_level = q.w_s2[q.r.pin_select];
      next_q.w_s3 = sel_level;
      pin_rise = sel_level && !q.w_s3;
      pin_fall = !sel_level && q.w_s3;
      stat_set = 3'b000;

      next_q.r.rise_flag = q.r.rise_flag | (d_rise & q.r.rise_en);
      next_q.r.fall_flag = q.r.fall_flag | (d_fall & q.r.fall_en);

      // ----------------------------------------
      // Noise filter after edge detection
      // ----------------------------------------
      // edge starts timer, level must hold
      case (q.st)
         FLT_IDLE: begin
            next_q.cnt = '0;
            if ((pin_rise && q.r.wake_rise_en) || (pin_fall && q.r.wake_fall_en)) begin
               next_q.st = FLT_COUNT;
               next_q.st_rise = pin_rise;
            end
         end
         FLT_COUNT: begin
            if (sel_level != q.st_rise) begin
               next_q.st = FLT_IDLE;
            end else if (q.cnt >= glitch_cycles(q.r.glitch_time) - CW'(1)) begin
               next_q.st = FLT_FIRE;
            end else begin
               next_q.cnt = q.cnt + CW'(1);
            end
         end
         FLT_FIRE: begin
            next_q.st = FLT_IDLE;
            if (q.st_rise && q.r.wake_rise_en) begin
               next_q.r.wake_rise_flag = 1'b1;
               stat_set[STAT_WAKE_RISE] = 1'b1;
            end
            if (!q.st_rise && q.r.wake_fall_en) begin
               next_q.r.wake_fall_flag = 1'b1;
               stat_set[STAT_WAKE_FALL] = 1'b1;
            end
         end
         default: next_q.st = FLT_IDLE;
      endcase
      stat_set[STAT_PIN] = |((d_rise & q.r.rise_en) | (d_fall & q.r.fall_en));

      // ----------------------------------------
      // Wishbone slave, one registered ack cycle, the cycle after the strobe
      // ----------------------------------------
      next_q.ack = cyc_i && stb_i && !q.ack;
      next_q.dat = '0;
      if (cyc_i && stb_i && !q.ack) begin
         if (hit(adr_i, ADDR_WAKE) && adr_i[1:0] == 2'b10) begin
            next_q.dat[7:0] = {q.r.wake_rise_flag, q.r.wake_fall_flag,
                               q.r.glitch_time, q.r.pin_select};
         end else if (hit(adr_i, ADDR_RISE)) next_q.dat[7:0] = q.r.rise_flag;
         else if (hit(adr_i, ADDR_FALL)) next_q.dat[7:0] = q.r.fall_flag;
         else if (hit(adr_i, ADDR_IRQ_STAT)) next_q.dat[2:0] = q.r.irq_stat;
         else if (hit(adr_i, ADDR_IRQ_MASK)) next_q.dat[2:0] = q.r.irq_mask;
         else if (hit(adr_i, ADDR_CTRL)) next_q.dat[0] = q.r.pin_irq_en;
         rd_sel = 1'b1;
      end
      // Wake register shares an aligned word with the rise register, so byte address offset 2 (adr_i[1:0] == 2'b10) selects it
      if (wr && hit(adr_i, ADDR_RISE) && adr_i[1:0] == 2'b00) begin
         next_q.r.rise_en = dat_i[7:0];
         next_q.r.rise_flag = next_q.r.rise_flag & dat_i[7:0];
      end
      if (wr && hit(adr_i, ADDR_FALL)) begin
         next_q.r.fall_en = dat_i[7:0];
         next_q.r.fall_flag = next_q.r.fall_flag & dat_i[7:0];
      end
      if (cyc_i && stb_i && we_i && !q.ack && adr_i[1:0] == 2'b10 && hit(adr_i, ADDR_WAKE)) begin
         next_q.r.wake_rise_en = dat_i[WAKE_RISE_BIT];
         next_q.r.wake_fall_en = dat_i[WAKE_FALL_BIT];
         next_q.r.glitch_time = dat_i[GLITCH_LSB +: 2];
         next_q.r.pin_select = dat_i[SEL_LSB +: 4];
         // flags cleared only by zero enable
         if (!dat_i[WAKE_RISE_BIT]) next_q.r.wake_rise_flag = 1'b0;
         if (!dat_i[WAKE_FALL_BIT]) next_q.r.wake_fall_flag = 1'b0;
      end
      if (wr && hit(adr_i, ADDR_IRQ_MASK)) next_q.r.irq_mask = dat_i[2:0];
      if (wr && hit(adr_i, ADDR_CTRL)) next_q.r.pin_irq_en = dat_i[0];
      // Set beats write-one-to-clear
      if (wr && hit(adr_i, ADDR_IRQ_STAT)) begin
         next_q.r.irq_stat = (q.r.irq_stat & ~dat_i[2:0]) | stat_set;
      end else begin
         next_q.r.irq_stat = q.r.irq_stat | stat_set;
      end

      next_q.edge_irq = q.r.pin_irq_en && |(q.r.rise_flag | q.r.fall_flag);
      next_q.wake = stat_set[STAT_PIN] || stat_set[STAT_WAKE_RISE] || stat_set[STAT_WAKE_FALL];
      next_q.irq = |(next_q.r.irq_stat & q.r.irq_mask);
      if (!rd_sel) next_q.dat = '0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign dat_o = q.dat;
   assign ack_o = q.ack;
   assign gpio_edge_irq_line_o = q.edge_irq;
   assign wake_o = q.wake;
   assign irq_o = q.irq;

   // ----------------------------------------
   // Check helpers
   // ----------------------------------------
   logic [7:0] wdat_lo;
   logic [7:0] wake_view;
   logic wake_wr;
   logic [CW-1:0] min_hold;
   assign wdat_lo = dat_i[7:0];
   assign wake_view = {q.r.wake_rise_flag, q.r.wake_fall_flag, q.r.glitch_time, q.r.pin_select};
   assign wake_wr = cyc_i && stb_i && we_i && !q.ack && adr_i == ADDR_WAKE;
   // Filter length from the code table itself, kept apart from the counter logic
   assign min_hold = CW'(BASE_CYC) << q.r.glitch_time;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_rise_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.d_s2[0] && !q.d_s3[0] && q.r.rise_en[0] && !wr) |=> q.r.rise_flag[0])
      else $error("rise flag not set");
   a_rise_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(q.r.rise_en[0]) |-> !q.r.rise_flag[0])
      else $error("rise flag survived enable clear");
   a_pin_irq_line: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.r.pin_irq_en && |q.r.rise_flag) |=> gpio_edge_irq_line_o)
      else $error("pin interrupt missing");
   a_fall_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (!q.d_s2[0] && q.d_s3[0] && q.r.fall_en[0] && !wr) |=> q.r.fall_flag[0])
      else $error("fall flag not set");
   a_fall_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(q.r.fall_en[0]) |-> !q.r.fall_flag[0])
      else $error("fall flag survived enable clear");
   a_edge_wakes_cpu: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(q.d_s2 & ~q.d_s3 & q.r.rise_en)) |=> wake_o)
      else $error("edge did not wake cpu");
   a_short_pulse_dropped: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.st == FLT_COUNT && sel_level != q.st_rise) |=> q.st == FLT_IDLE)
      else $error("short pulse not filtered");
   a_wake_flag_timing: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.st == FLT_FIRE && q.st_rise && q.r.wake_rise_en) |=> q.r.wake_rise_flag)
      else $error("wake rise flag not set");
   a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held two cycles");

   // ----------------------------------------
   // Register bus checks
   // ----------------------------------------

   a_rise_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !we_i && !ack_o && adr_i == ADDR_RISE) |=> dat_o[7:0] == $past(q.r.rise_flag))
      else $error("rise read data wrong");

   a_fall_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !we_i && !ack_o && adr_i == ADDR_FALL) |=> dat_o[7:0] == $past(q.r.fall_flag))
      else $error("fall read data wrong");

   a_wake_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !we_i && !ack_o && adr_i == ADDR_WAKE) |=> dat_o[7:0] == $past(wake_view))
      else $error("wake read data wrong");

   a_rise_en_load: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && adr_i == ADDR_RISE) |=> q.r.rise_en == $past(wdat_lo))
      else $error("rise enables not loaded");

   a_fall_en_load: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && adr_i == ADDR_FALL) |=> q.r.fall_en == $past(wdat_lo))
      else $error("fall enables not loaded");

   a_wake_cfg_load: assert property (@(posedge clk_i) disable iff (rst_i)
      wake_wr |=> {q.r.wake_rise_en, q.r.wake_fall_en, q.r.glitch_time, q.r.pin_select}
         == $past(wdat_lo))
      else $error("wake config not loaded");

   a_rise_mask_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && adr_i == ADDR_RISE) |=> (q.r.rise_flag & ~q.r.rise_en) == 8'h00)
      else $error("rise flag kept without enable");

   a_fall_mask_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && adr_i == ADDR_FALL) |=> (q.r.fall_flag & ~q.r.fall_en) == 8'h00)
      else $error("fall flag kept without enable");

   // Bus answers only a request
   a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
      !(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without request");

   // Read data is zero outside the answer
   a_read_zero_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !ack_o |-> dat_o == 32'h00000000)
      else $error("read data without ack");

   // Status bit stays until cleared
   a_stat_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.r.irq_stat[STAT_PIN] && !(wr && adr_i == ADDR_IRQ_STAT)) |=> q.r.irq_stat[STAT_PIN])
      else $error("status bit lost");

   // ----------------------------------------
   // Edge and wake checks
   // ----------------------------------------

   a_fall_irq_line: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.r.pin_irq_en && |q.r.fall_flag) |=> gpio_edge_irq_line_o)
      else $error("fall interrupt missing");

   a_irq_line_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.r.pin_irq_en |=> !gpio_edge_irq_line_o)
      else $error("pin interrupt without enable");

   a_fall_wakes_cpu: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(~q.d_s2 & q.d_s3 & q.r.fall_en)) |=> wake_o)
      else $error("fall edge did not wake cpu");

   a_edge_sets_status: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(q.d_s2 & ~q.d_s3 & q.r.rise_en)) |=> q.r.irq_stat[STAT_PIN])
      else $error("edge status not set");

   a_no_rise_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.d_s2 == q.d_s3) |=> (q.r.rise_flag & ~$past(q.r.rise_flag)) == 8'h00)
      else $error("rise flag without edge");

   a_no_fall_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.d_s2 == q.d_s3) |=> (q.r.fall_flag & ~$past(q.r.fall_flag)) == 8'h00)
      else $error("fall flag without edge");

   a_filter_idle_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.st == FLT_IDLE && !q.r.wake_rise_en && !q.r.wake_fall_en) |=> q.st == FLT_IDLE)
      else $error("filter started while disabled");

   a_filter_full_time: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.st == FLT_FIRE && $stable(q.r.glitch_time)) |-> q.cnt + CW'(1) >= min_hold)
      else $error("filter fired early");

   a_wake_fall_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.st == FLT_FIRE && !q.st_rise && q.r.wake_fall_en && !wake_wr) |=> q.r.wake_fall_flag)
      else $error("wake fall flag not set");

   a_wake_rise_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (wake_wr && !wdat_lo[WAKE_RISE_BIT]) |=> !q.r.wake_rise_flag)
      else $error("wake rise flag not cleared");

   a_wake_fall_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (wake_wr && !wdat_lo[WAKE_FALL_BIT]) |=> !q.r.wake_fall_flag)
      else $error("wake fall flag not cleared");

   a_rise_via_filter: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.st != FLT_FIRE) |=> !$rose(q.r.wake_rise_flag))
      else $error("wake rise flag bypassed filter");

   a_fall_via_filter: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.st != FLT_FIRE) |=> !$rose(q.r.wake_fall_flag))
      else $error("wake fall flag bypassed filter");

endmodule : gpio_edge_detect_wakeup

// ### gpio_wake_pkg.sv
package gpio_wake_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [15:0] ADDR_RISE = 16'ha02c;
   localparam logic [15:0] ADDR_WAKE = 16'ha02e;
   localparam logic [15:0] ADDR_FALL = 16'ha03c;
   localparam logic [15:0] ADDR_IRQ_STAT = 16'ha040;
   localparam logic [15:0] ADDR_IRQ_MASK = 16'ha044;
   localparam logic [15:0] ADDR_CTRL = 16'ha048;

   // ----------------------------------------
   // Field layout and reset values
   // ----------------------------------------
   localparam int WAKE_RISE_BIT = 7;
   localparam int WAKE_FALL_BIT = 6;
   localparam int GLITCH_LSB = 4;
   localparam int SEL_LSB = 0;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int STAT_PIN = 0;
   localparam int STAT_WAKE_RISE = 1;
   localparam int STAT_WAKE_FALL = 2;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int GLITCH_BASE_MS = 1;
   localparam int GLITCH_BASE_CYC = GLITCH_BASE_MS * CLK_MHZ * 1000;

   typedef enum logic [1:0] {
      FLT_IDLE = 2'b00,
      FLT_COUNT = 2'b01,
      FLT_FIRE = 2'b11
   } flt_state_e;

   typedef struct packed {
      logic [7:0] rise_flag;
      logic [7:0] rise_en;
      logic [7:0] fall_flag;
      logic [7:0] fall_en;
      logic wake_rise_en;
      logic wake_fall_en;
      logic wake_rise_flag;
      logic wake_fall_flag;
      logic [1:0] glitch_time;
      logic [3:0] pin_select;
      logic pin_irq_en;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
   } regs_s;

endpackage : gpio_wake_pkg

// ### pin_drive.sv
`timescale 1ns/1ns
module pin_drive (
   input wire logic clk_i, // Bench clock
   output logic [7:0] pd_o = 8'h00, // Port 4 pins
   output logic [7:0] pa_o = 8'h00, // Port 0 pins
   output logic [7:0] pb_o = 8'h00 // Port 1 pins
);
   // Pins move on the sampling edge itself, by nonblocking update after that edge has sampled them
   task automatic put(input logic [7:0] d, input logic [7:0] a, input logic [7:0] b);
      @(posedge clk_i);
      pd_o <= d;
      pa_o <= a;
      pb_o <= b;
   endtask : put
endmodule : pin_drive

// ### tb_top.sv
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
   $display("unexpected %0t got %h want %h", $time, a, e); end end
module tb_top;
   import gpio_wake_pkg::*;
   typedef struct packed {logic [7:0] er, ef, p0, p1, xr, xf;} row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc, stb, we, ack, eirq, wake, irq;
   logic [15:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   logic [7:0] pd, pa, pb, cfg;
   int n_mismatch = 0;
   int comparisons = 0;
   int wake_n = 0;
   int w0, f;
   row_s rows[4] = '{'{8'hff, 8'h00, 8'h00, 8'ha5, 8'ha5, 8'h00},
      '{8'h0f, 8'hff, 8'hff, 8'h3c, 8'h00, 8'hc3},
      '{8'hff, 8'hff, 8'h0f, 8'hf0, 8'hf0, 8'h0f},
      '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00}};
   always #2 clk = ~clk;
   always @(posedge clk) if (wake === 1'b1) wake_n++;
   pin_drive pin_drive_i (.clk_i(clk), .pd_o(pd), .pa_o(pa), .pb_o(pb));
   // Short filter base so every filter code finishes in a few dozen cycles
   gpio_edge_detect_wakeup #(.BASE_CYC(4)) gpio_edge_detect_wakeup_i (.clk_i(clk),
      .rst_i(rst), .port_d_pin_i(pd), .port_a_pin_i(pa), .port_b_pin_i(pb),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .gpio_edge_irq_line_o(eirq), .wake_o(wake), .irq_o(irq));
   // ----------------------------------------
   // Bus, pin pulse and end-of-test tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d,
      output logic [7:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         n_mismatch++;
         stop_test();
      end
   endtask : wb
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      `CHK(q, e)
   endtask : rd_chk
   // Width counts whole cycles; port D pins are driven low and only the selected wake pin pulses
   task automatic pulse(input logic [3:0] s, input int w);
      logic [15:0] m;
      m = 16'h0001 << s;
      pin_drive_i.put(8'h00, m[7:0], m[15:8]);
      repeat (w - 1) @(posedge clk);
      pin_drive_i.put(8'h00, 8'h00, 8'h00);
   endtask : pulse
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 16'h0000;
      sel = 4'hf;
      wdat = 32'h00000000;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_chk(ADDR_RISE, RESET_BYTE);
      rd_chk(ADDR_FALL, RESET_BYTE);
      rd_chk(ADDR_WAKE, RESET_BYTE);
      wr(16'ha050, 8'hff);
      rd_chk(16'ha050, 8'h00);
      wr(ADDR_CTRL, 8'h01);
      $display("reset test done");
      foreach (rows[i]) begin
         pin_drive_i.put(rows[i].p0, 8'h00, 8'h00);
         repeat (6) @(posedge clk);
         wr(ADDR_RISE, rows[i].er);
         wr(ADDR_FALL, rows[i].ef);
         w0 = wake_n;
         pin_drive_i.put(rows[i].p1, 8'h00, 8'h00);
         repeat (6) @(posedge clk);
         rd_chk(ADDR_RISE, rows[i].xr);
         rd_chk(ADDR_FALL, rows[i].xf);
         `CHK(eirq, |(rows[i].xr | rows[i].xf))
         `CHK(wake_n != w0, |(rows[i].xr | rows[i].xf))
         wr(ADDR_RISE, 8'h00);
         wr(ADDR_FALL, 8'h00);
         rd_chk(ADDR_RISE, 8'h00);
         rd_chk(ADDR_FALL, 8'h00);
         $display("row %0d done", i);
      end
      `CHK(irq, 1'b0)
      wr(ADDR_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      wr(ADDR_IRQ_STAT, 8'h01);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      $display("irq test done");
      for (int c = 0; c < 4; c++) begin
         cfg = {2'b00, 2'(c), 4'(c * 5)};
         f = 4 << c;
         w0 = wake_n;
         wr(ADDR_WAKE, cfg | 8'h80);
         pulse(cfg[3:0], f / 2);
         repeat (3 * f) @(posedge clk);
         rd_chk(ADDR_WAKE, cfg);
         wr(ADDR_WAKE, cfg | 8'hc0);
         pulse(cfg[3:0], 2 * f);
         repeat (3 * f) @(posedge clk);
         rd_chk(ADDR_WAKE, cfg | 8'hc0);
         `CHK(wake_n - w0, 2)
         wr(ADDR_WAKE, cfg);
         rd_chk(ADDR_WAKE, cfg);
         $display("wake code %0d done", c);
      end
      stop_test();
   end
endmodule : tb_top
